// file: logic/nand_bus_host.sv
`timescale 1ns/1ps
// Summary of operation
// - bytes one, two carry column bits
// - bytes three to five carry page, block
// - column bit 12 low; spare range limit
// - host holds read strobe high when busy
// - full address as five address cycles
module nand_bus_host
   import nand_host_pkg::*;
#(
   parameter int LOW_CYC = STROBE_LOW_CYC,
   parameter int HIGH_CYC = STROBE_HIGH_CYC,
   parameter int ACCESS_CYC = READ_ACCESS_CYC
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // user requests
   input wire logic reqValid,
   input wire host_req_s req,
   input wire logic allowModify,
   input wire logic protectEnable,
   output logic reqReady,
   // user answers
   output logic rdValid,
   output logic [7:0] rdData,
   output logic addrError,
   output logic planeSel,
   output logic deviceBusy,
   // device pins
   output logic cmdLatch,
   output logic addrLatch,
   output logic chipSelN,
   output logic writeStrobeN,
   output logic readStrobeN,
   output logic writeProtectN,
   output logic volatileProtectEnable,
   output logic [7:0] busOut,
   output logic busOe,
   input wire logic [7:0] busIn,
   input wire logic readyBusyN
);
   initial begin
      if (LOW_CYC < 1 || HIGH_CYC < 1 || ACCESS_CYC < 1 || ACCESS_CYC > LOW_CYC + 1)
         $error("nand_bus_host: strobe timing parameters out of range");
   end

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SETUP = 3'b001,
      ST_LOW = 3'b011,
      ST_HIGH = 3'b010,
      ST_NEXT = 3'b110
   } state_e;

   state_e state_r, state_nxt;
   logic [7:0] cnt_r, cnt_nxt;
   logic [2:0] byteIdx_r;
   host_req_s cur_r;
   logic [7:0] busIn2;
   logic rdyN2;
   logic sampleD1_r, sampleD2_r;

   pin_sync #(.WIDTH(9)) u_sync (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .async({readyBusyN, busIn}),
      .synced({rdyN2, busIn2})
   );

   // address byte mapping
   wire nand_addr_s a = cur_r.addr;
   wire [7:0] addrByte [ADDR_BYTES];
   assign addrByte[0] = a.column[7:0];
   assign addrByte[1] = {3'h0, 1'b0, a.column[11:8]};
   assign addrByte[2] = {a.block[1:0], a.page};
   assign addrByte[3] = a.block[9:2];
   assign addrByte[4] = {6'h00, a.block[11:10]};
   wire isFull = cur_r.op == OP_FULLADDR;
   wire isWrite = cur_r.op != OP_RDATA;
   wire [7:0] outByte = isFull ? addrByte[byteIdx_r] : cur_r.data;
   wire lastByte = !isFull || byteIdx_r == 3'(ADDR_BYTES - 1);
   wire badAddr = req.op == OP_FULLADDR && req.addr.column[11] &&
                  req.addr.column[10:7] != COL_SPARE_MASK;
   wire busy = !rdyN2;
   wire accept = reqValid && state_r == ST_IDLE && !busy;
   wire phaseDone = cnt_r == 8'h00;
   wire sampleRead = state_r == ST_LOW && !isWrite &&
                     cnt_r == 8'(LOW_CYC - ACCESS_CYC);

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = phaseDone ? 8'h00 : cnt_r - 8'h01;
      case (state_r)
         ST_IDLE: if (accept) begin
            state_nxt = ST_SETUP;
         end
         ST_SETUP: begin
            state_nxt = ST_LOW;
            cnt_nxt = 8'(LOW_CYC - 1);
         end
         ST_LOW: if (phaseDone) begin
            state_nxt = ST_HIGH;
            cnt_nxt = 8'(HIGH_CYC - 1);
         end
         ST_HIGH: if (phaseDone) begin
            state_nxt = lastByte ? ST_NEXT : ST_SETUP;
            cnt_nxt = lastByte ? 8'(BUSY_SETTLE_CYC) : 8'h00;
         end
         // wait out the busy synchroniser before taking the next request
         ST_NEXT: if (phaseDone) begin
            state_nxt = ST_IDLE;
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state_r <= ST_IDLE;
         cnt_r <= 8'h00;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cur_r <= '0;
         byteIdx_r <= 3'h0;
         addrError <= 1'b0;
         planeSel <= 1'b0;
      end else if (accept) begin
         cur_r <= req;
         byteIdx_r <= 3'h0;
         addrError <= badAddr;
         if (req.op == OP_FULLADDR) begin
            planeSel <= req.addr.block[0];
         end
      end else if (state_r == ST_HIGH && phaseDone && !lastByte) begin
         byteIdx_r <= byteIdx_r + 3'h1;
      end
   end

   wire strobeLow = state_r == ST_LOW;
   wire inCycle = state_r != ST_IDLE;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cmdLatch <= 1'b0;
         addrLatch <= 1'b0;
         chipSelN <= 1'b1;
         writeStrobeN <= 1'b1;
         readStrobeN <= 1'b1;
         busOut <= 8'h00;
         busOe <= 1'b0;
      end else begin
         cmdLatch <= inCycle && cur_r.op == OP_CMD;
         addrLatch <= inCycle && (cur_r.op == OP_ADDR || isFull);
         chipSelN <= !(state_nxt != ST_IDLE);
         writeStrobeN <= !(state_nxt == ST_LOW && isWrite);
         readStrobeN <= !(state_nxt == ST_LOW && !isWrite);
         busOut <= outByte;
         busOe <= state_nxt != ST_IDLE && state_nxt != ST_NEXT &&
                  (accept ? req.op != OP_RDATA : isWrite);
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         writeProtectN <= 1'b0;
         volatileProtectEnable <= 1'b0;
         reqReady <= 1'b0;
         rdValid <= 1'b0;
         rdData <= 8'h00;
         deviceBusy <= 1'b0;
         sampleD1_r <= 1'b0;
         sampleD2_r <= 1'b0;
      end else begin
         writeProtectN <= allowModify;
         volatileProtectEnable <= protectEnable;
         reqReady <= state_nxt == ST_IDLE && !busy;
         // read byte needs two more cycles through the bus synchroniser
         sampleD1_r <= sampleRead;
         sampleD2_r <= sampleD1_r;
         rdValid <= sampleD2_r;
         if (sampleD2_r) begin
            rdData <= busIn2;
         end
         deviceBusy <= busy;
      end
   end

   a_read_hold_busy: assert property (@(posedge clk_sys) disable iff (!resetn)
      busy && state_r == ST_IDLE |=> readStrobeN)
      else $error("read strobe fell while busy");
   a_five_addr_cycles: assert property (@(posedge clk_sys) disable iff (!resetn)
      accept && req.op == OP_FULLADDR |=> byteIdx_r == 3'h0 ##1 !(byteIdx_r > 3'h4)
      [*8])
      else $error("address byte index beyond five");
   a_col12_low: assert property (@(posedge clk_sys) disable iff (!resetn)
      addrLatch && isFull && byteIdx_r == 3'h1 && state_r == ST_LOW |->
      busOut[7:4] == 4'h0)
      else $error("column bit 12 driven high");
   a_strobe_excl: assert property (@(posedge clk_sys) disable iff (!resetn)
      !(cmdLatch && addrLatch) && (writeStrobeN || readStrobeN))
      else $error("conflicting strobes");
   a_sel_strobe: assert property (@(posedge clk_sys) disable iff (!resetn)
      $fell(writeStrobeN) |-> !chipSelN && busOe)
      else $error("write strobe without select");
endmodule : nand_bus_host

// file: logic/nand_host_pkg.sv
package nand_host_pkg;
   // bus cycle kinds the user may request
   typedef enum logic [2:0] {
      OP_CMD = 3'h0,
      OP_ADDR = 3'h1,
      OP_WDATA = 3'h2,
      OP_RDATA = 3'h3,
      OP_FULLADDR = 3'h4
   } op_e;

   // clock figures
   localparam int CLK_PERIOD_NS = 40;
   localparam int STROBE_LOW_NS = 25;
   localparam int STROBE_HIGH_NS = 15;
   localparam int READ_ACCESS_DELAY_NS = 20;
   // cycles held after a last strobe so a new busy reaches the synchroniser output
   localparam int BUSY_SETTLE_CYC = 2;
   localparam int STROBE_LOW_CYC =
      (STROBE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_HIGH_CYC =
      (STROBE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_ACCESS_CYC =
      (READ_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // address layout
   localparam int COL_BITS = 12;
   localparam int PAGE_BITS = 6;
   localparam int BLOCK_BITS = 12;
   localparam int ADDR_BYTES = 5;
   localparam logic [3:0] COL_SPARE_MASK = 4'h0;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   // a full memory address
   typedef struct packed {
      logic [BLOCK_BITS-1:0] block;
      logic [PAGE_BITS-1:0] page;
      logic [COL_BITS-1:0] column;
   } nand_addr_s;

   // one request from the user side
   typedef struct packed {
      op_e op;
      logic [7:0] data;
      nand_addr_s addr;
   } host_req_s;

   // pin levels the controller drives
   typedef struct packed {
      logic cmdLatch;
      logic addrLatch;
      logic chipSelN;
      logic writeStrobeN;
      logic readStrobeN;
      logic writeProtectN;
      logic volProtectEn;
   } nand_ctl_s;

   localparam nand_ctl_s CTL_IDLE = 7'b0011100;
endpackage : nand_host_pkg

// file: logic/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // raw and synchronised levels
   input wire logic [WIDTH-1:0] async,
   output logic [WIDTH-1:0] synced
);
   logic [WIDTH-1:0] stage1_r;

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         stage1_r <= '0;
         synced <= '0;
      end else begin
         stage1_r <= async;
         synced <= stage1_r;
      end
   end
endmodule : pin_sync

// file: sim/nand_dev_model.sv
`timescale 1ns/1ps
module nand_dev_model (
   // host pins
   input wire logic cmdLatch,
   input wire logic addrLatch,
   input wire logic chipSelN,
   input wire logic writeStrobeN,
   input wire logic readStrobeN,
   input wire logic writeProtectN,
   input wire logic [7:0] busOut,
   // device outputs
   output logic [7:0] busIn,
   output logic readyBusyN
);
   logic [7:0] mem [4096];
   logic [7:0] addrByte [5];
   logic [7:0] lastCmd = 8'h00;
   logic [7:0] rdByte = 8'h00;
   logic [11:0] col = 12'h000;
   logic busy = 1'b0;
   int addrCnt = 0;
   wire selected = !chipSelN && !busy;
   wire driving = selected && !readStrobeN;
   // released bus shows the inverse, not a stale byte
   assign busIn = driving ? rdByte : ~rdByte;
   assign readyBusyN = busy ? 1'b0 : 1'b1;
   always @(negedge readStrobeN) begin
      if (selected) begin
         rdByte <= #20 mem[col];
         col <= col + 12'h001;
      end
   end
   always @(posedge writeStrobeN) begin
      if (selected && cmdLatch && !addrLatch) begin
         lastCmd = busOut;
         addrCnt = 0;
         busy = (busOut == 8'h10) && writeProtectN;
      end else if (selected && addrLatch && !cmdLatch) begin
         addrByte[addrCnt%5] = busOut;
         addrCnt++;
         if (addrCnt % 5 == 2) col = {addrByte[1][3:0], addrByte[0]};
      end else if (selected && readStrobeN && writeProtectN) begin
         mem[col] = busOut;
         col++;
      end
   end
   // program time, kept short
   always @(posedge busy) begin
      #800;
      busy = 1'b0;
   end
endmodule : nand_dev_model

// file: sim/nand_bus_host_tb.sv
`timescale 1ns/1ps
module nand_bus_host_tb;
   import nand_host_pkg::*;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic reqValid = 1'b0;
   host_req_s req = '0;
   logic allowModify = 1'b1;
   logic protectEnable = 1'b1;
   int nRd = 0;
   logic reqReady, rdValid, addrError, planeSel, deviceBusy, cmdLatch, addrLatch, chipSelN;
   logic writeStrobeN, readStrobeN, writeProtectN, volatileProtectEnable, busOe, readyBusyN;
   logic [7:0] rdData, busOut, busIn;
   nand_addr_s a;
   int err_count = 0;
   int n_compared = 0;
   always #20 clk_sys = ~clk_sys;
   nand_bus_host dut (.clk_sys(clk_sys), .resetn(resetn), .reqValid(reqValid), .req(req),
      .allowModify(allowModify), .protectEnable(protectEnable), .reqReady(reqReady),
      .rdValid(rdValid), .rdData(rdData), .addrError(addrError), .planeSel(planeSel),
      .deviceBusy(deviceBusy), .cmdLatch(cmdLatch), .addrLatch(addrLatch),
      .chipSelN(chipSelN), .writeStrobeN(writeStrobeN), .readStrobeN(readStrobeN),
      .writeProtectN(writeProtectN), .volatileProtectEnable(volatileProtectEnable),
      .busOut(busOut), .busOe(busOe), .busIn(busIn), .readyBusyN(readyBusyN));
   nand_dev_model model (.cmdLatch(cmdLatch), .addrLatch(addrLatch), .chipSelN(chipSelN),
      .writeStrobeN(writeStrobeN), .readStrobeN(readStrobeN),
      .writeProtectN(writeProtectN), .busOut(busOut), .busIn(busIn),
      .readyBusyN(readyBusyN));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic issue(input op_e op, input logic [7:0] d);
      int n;
      n = 0;
      @(negedge clk_sys);
      while (reqReady !== 1'b1 && n < 2000) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 2000) err_count++;
      @(posedge clk_sys);
      req <= '{op: op, data: d, addr: a};
      reqValid <= 1'b1;
      @(posedge clk_sys);
      reqValid <= 1'b0;
      repeat (2) @(posedge clk_sys);
      // transfer ends when the controller deselects
      n = 0;
      @(negedge clk_sys);
      while (chipSelN !== 1'b1 && n < 2000) begin
         @(negedge clk_sys);
         n++;
      end
      if (n >= 2000) err_count++;
   endtask : issue
   task automatic conclude();
      $display("compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude
   // no read strobe while the device is busy
   always @(negedge readStrobeN) check({7'h0, readyBusyN}, 8'h01);
   always @(posedge clk_sys) if (rdValid === 1'b1) nRd++;
   initial begin : watchdog
      #200000;
      err_count++;
      $display("watchdog expired");
      conclude();
   end
   initial begin : main
      a = '{block: 12'hA5B, page: 6'h2C, column: 12'h812};
      repeat (2) @(posedge clk_sys);
      check({6'h0, chipSelN, writeProtectN}, 8'h02);
      repeat (3) @(posedge clk_sys);
      resetn <= 1'b1;
      issue(OP_CMD, 8'h80);
      check(model.lastCmd, 8'h80);
      issue(OP_FULLADDR, 8'h00);
      check(model.addrByte[0], 8'h12);
      check(model.addrByte[1], 8'h08);
      check(model.addrByte[2], 8'hEC);
      check(model.addrByte[3], 8'h96);
      check(model.addrByte[4], 8'h02);
      check({6'h0, planeSel, addrError}, 8'h02);
      check({7'h0, volatileProtectEnable}, 8'h01);
      issue(OP_WDATA, 8'h5A);
      issue(OP_WDATA, 8'hC3);
      check(model.mem[12'h812], 8'h5A);
      check(model.mem[12'h813], 8'hC3);
      $display("data input test done");
      allowModify <= 1'b0;
      issue(OP_FULLADDR, 8'h00);
      issue(OP_WDATA, 8'hFF);
      check(model.mem[12'h812], 8'h5A);
      allowModify <= 1'b1;
      issue(OP_FULLADDR, 8'h00);
      issue(OP_RDATA, 8'h00);
      check(rdData, 8'h5A);
      issue(OP_RDATA, 8'h00);
      check(rdData, 8'hC3);
      check(8'(nRd), 8'h02);
      $display("protect and read test done");
      a.column = 12'h8F0;
      issue(OP_FULLADDR, 8'h00);
      check({7'h0, addrError}, 8'h01);
      issue(OP_CMD, 8'h10);
      repeat (4) @(posedge clk_sys);
      check({6'h0, deviceBusy, reqReady}, 8'h02);
      issue(OP_CMD, 8'h70);
      check(model.lastCmd, 8'h70);
      issue(OP_ADDR, 8'h00);
      check(model.addrByte[0], 8'h00);
      protectEnable <= 1'b0;
      repeat (2) @(posedge clk_sys);
      check({7'h0, volatileProtectEnable}, 8'h00);
      $display("busy test done");
      conclude();
   end
endmodule : nand_bus_host_tb
